//--- design/citc_core_config.sv
// core configuration glue: code/system bus ports, tick timer, priorities, nmi
//
// Behaviour
// (RL1) fetch and data-code buses share one port
// (RL2) system bus has its own master port
// (RL3) tick timer counts on core clock only
// (RL4) tick clock select bit always reads one
// (RL5) ten ms calibration count reads zero
// (RL6) no reference flag always reads one
// (RL7) sixteen priority levels, four-bit fields
// (RL8) nmi request follows the external pin
// (RL9) software must route pin to nmi
// (RL10) nmi pin active low, gated by mux
// (RL11) priority in upper nibble, lower reads zero
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module citc_core_config
(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // instruction fetch bus from the core
  input  wire logic                    fetch_valid,
  input  wire citc_pkg::citc_req_t     fetch_req,
  output logic                         fetch_ready,
  output logic                         fetch_rvalid,
  output logic [31:0]                  fetch_rdata,
  // data code bus from the core
  input  wire logic                    data_code_bus_valid,
  input  wire citc_pkg::citc_req_t     data_code_bus_req,
  output logic                         data_code_bus_ready,
  output logic                         data_code_bus_rvalid,
  output logic [31:0]                  data_code_bus_rdata,
  // merged code bus master port toward the crossbar
  output logic                         code_valid,
  output citc_pkg::citc_req_t          code_req,
  input  wire logic                    code_ready,
  input  wire logic                    code_rvalid,
  input  wire logic [31:0]             code_rdata,
  // system bus from the core
  input  wire logic                    sys_in_valid,
  input  wire citc_pkg::citc_req_t     sys_in_req,
  output logic                         sys_in_ready,
  // system bus master port toward the crossbar
  output logic                         sys_valid,
  output citc_pkg::citc_req_t          sys_req,
  input  wire logic                    sys_ready,
  // external nmi pin
  input  wire logic                    nmi_pin_n,
  // toward the vectored irq controller
  output logic                         nmi_request,
  output logic                         tick_event,
  output logic [citc_pkg::PRIO_SOURCES*citc_pkg::PRIO_BITS-1:0] irq_priority
);

  // address match on the low byte with the upper bytes zero, used for every register
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
    hit = (addr[citc_pkg::ADDR_W-1:0] == off) && (addr[31:citc_pkg::ADDR_W] == 24'h00_0000);
  endfunction

  // ---------------- code bus merge ----------------
  logic                 code_busy;      // request held on the port
  citc_pkg::citc_owner_t owner;         // who gets the read answer
  logic                 fetch_rv_q;     // answer flags, registered
  logic                 data_code_bus_rv_q;
  logic [31:0]          code_rdata_q;   // answer data, registered
  wire                  code_load;      // port slot may take a new request
  wire                  pick_data;      // data code wins when both ask

  // data accesses go first: a stalled load costs more than a late fetch
  assign code_load   = ~code_busy | code_ready;
  assign pick_data   = data_code_bus_valid;
  assign data_code_bus_ready = code_load & pick_data;                  // see (RL1)
  assign fetch_ready = code_load & ~pick_data;                 // see (RL1)
  assign code_valid  = code_busy;

  // one slot: load the chosen source whenever the port is free or draining
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_busy <= 1'b0;
      code_req  <= '0;
      owner     <= citc_pkg::CITC_OWN_FETCH;
    end
    else if (code_load)
    begin
      code_busy <= data_code_bus_valid | fetch_valid;
      // both sources funnel into the single port register
      if (pick_data)
      begin
        code_req <= data_code_bus_req;                                 // see (RL1)
        owner    <= citc_pkg::CITC_OWN_DATA;
      end
      else if (fetch_valid)
      begin
        code_req <= fetch_req;                                 // see (RL1)
        owner    <= citc_pkg::CITC_OWN_FETCH;
      end
    end
  end

  // route the read answer back by owner; one outstanding transfer is assumed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_rv_q   <= 1'b0;
      data_code_bus_rv_q   <= 1'b0;
      code_rdata_q <= citc_pkg::WORD_ZERO;
    end
    else
    begin
      fetch_rv_q <= code_rvalid & (owner == citc_pkg::CITC_OWN_FETCH);
      data_code_bus_rv_q <= code_rvalid & (owner == citc_pkg::CITC_OWN_DATA);
      if (code_rvalid)
        code_rdata_q <= code_rdata;
    end
  end

  assign fetch_rvalid = fetch_rv_q;
  assign data_code_bus_rvalid = data_code_bus_rv_q;
  assign fetch_rdata  = code_rdata_q;
  assign data_code_bus_rdata  = code_rdata_q;

  // ---------------- system bus port ----------------
  wire sys_load;

  assign sys_load     = ~sys_valid | sys_ready;
  assign sys_in_ready = sys_load;                              // see (RL2)

  // separate slot, never shared with the code port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_valid <= 1'b0;
      sys_req   <= '0;
    end
    else if (sys_load)
    begin
      sys_valid <= sys_in_valid;                               // see (RL2)
      if (sys_in_valid)
        sys_req <= sys_in_req;
    end
  end

  // ---------------- apb decode ----------------
  wire apb_setup;
  wire apb_wr;
  wire hit_ctrl;
  wire hit_load;
  wire hit_cur;
  wire hit_calib;
  wire hit_mux;
  wire hit_stat;
  wire hit_prio;
  wire [1:0] prio_idx;
  wire mapped;

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;   // writes land at the access edge
  assign hit_ctrl  = hit(paddr, citc_pkg::OFF_TICK_CTRL);
  assign hit_load  = hit(paddr, citc_pkg::OFF_TICK_LOAD);
  assign hit_cur   = hit(paddr, citc_pkg::OFF_TICK_CUR);
  assign hit_calib = hit(paddr, citc_pkg::OFF_TICK_CALIB);
  assign hit_mux   = hit(paddr, citc_pkg::OFF_NMI_MUX);
  assign hit_stat  = hit(paddr, citc_pkg::OFF_STATUS);
  assign prio_idx  = paddr[3:2];
  assign hit_prio  = hit({paddr[31:4], 4'h0}, citc_pkg::OFF_PRIO_BASE) & (paddr[1:0] == 2'h0);
  assign mapped    = hit_ctrl | hit_load | hit_cur | hit_calib | hit_mux | hit_stat | hit_prio;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------- system tick timer ----------------
  logic                          tick_enable;
  logic                          tick_int_en;
  logic                          count_flag;
  logic [citc_pkg::TICK_W-1:0]   tick_reload;
  logic [citc_pkg::TICK_W-1:0]   tick_count;
  wire                           tick_wrap;
  wire                           flag_clear;

  // counts every core clock edge; there is no other reference to pick
  assign tick_wrap  = tick_enable & (tick_count == citc_pkg::TICK_ONE); // see (RL3)
  // reading control or writing current clears the flag
  assign flag_clear = (psel & penable & ~pwrite & hit_ctrl) | (apb_wr & hit_cur);

  // control bits written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_enable <= 1'b0;
      tick_int_en <= 1'b0;
      tick_reload <= citc_pkg::TICK_ZERO;
    end
    else
    begin
      if (apb_wr & hit_ctrl)
      begin
        tick_enable <= pwdata[citc_pkg::CTRL_ENABLE_BIT];
        tick_int_en <= pwdata[citc_pkg::CTRL_TICKINT_BIT];
      end
      if (apb_wr & hit_load)
        tick_reload <= pwdata[citc_pkg::TICK_W-1:0];
    end
  end

  // down counter: a write clears it, zero reloads on the next edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_count <= citc_pkg::TICK_ZERO;
    else if (apb_wr & hit_cur)
      tick_count <= citc_pkg::TICK_ZERO;
    else if (tick_enable)
      tick_count <= (tick_count == citc_pkg::TICK_ZERO) ? tick_reload :
                    (tick_count - citc_pkg::TICK_ONE);   // see (RL3)
  end

  // sticky flag: a wrap in the clearing cycle keeps it set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_flag <= 1'b0;
    else if (tick_wrap)
      count_flag <= 1'b1;
    else if (flag_clear)
      count_flag <= 1'b0;
  end

  // one-cycle exception request to the controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_event <= 1'b0;
    else
      tick_event <= tick_wrap & tick_int_en;
  end

  // ---------------- priority registers ----------------
  logic [31:0] prio_word [citc_pkg::PRIO_REGS];

  // each word keeps only the upper nibble of every byte
  genvar gi;
  generate
    for (gi = 0; gi < citc_pkg::PRIO_REGS; gi++)
    begin : g_prio
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          prio_word[gi] <= citc_pkg::WORD_ZERO;
        else if (apb_wr & hit_prio & (prio_idx == 2'(gi)))
          prio_word[gi] <= pwdata & citc_pkg::PRIO_MASK;       // see (RL11)
      end
      // four sources per word, four bits each
      for (genvar gb = 0; gb < 4; gb++)
      begin : g_src
        assign irq_priority[(gi*4+gb)*citc_pkg::PRIO_BITS +: citc_pkg::PRIO_BITS] =
          prio_word[gi][gb*8+citc_pkg::PRIO_LSB +: citc_pkg::PRIO_BITS];  // see (RL7)
      end
    end
  endgenerate

  // ---------------- nmi pin mux ----------------
  logic [citc_pkg::MUX_W-1:0] pin_mux_sel;

  // pin function select; reset leaves the pin off the nmi function
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_mux_sel <= citc_pkg::MUX_RESET;
    else if (apb_wr & hit_mux)
      pin_mux_sel <= pwdata[citc_pkg::MUX_W-1:0];              // see (RL9)
  end

  citc_nmi_gate u_nmi
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .nmi_pin_n   (nmi_pin_n),
    .pin_mux_sel (pin_mux_sel),
    .nmi_request (nmi_request)                                 // see (RL8)
  );

  // ---------------- read data ----------------
  wire [31:0] rd_ctrl;
  wire [31:0] rd_calib;
  wire [31:0] rd_stat;
  wire [31:0] next_rdata;

  assign rd_ctrl = (32'h0000_0001 << citc_pkg::CTRL_CLKSEL_BIT)            // see (RL4)
                 | ({31'h0000_0000, count_flag} << citc_pkg::CTRL_FLAG_BIT)
                 | ({31'h0000_0000, tick_int_en} << citc_pkg::CTRL_TICKINT_BIT)
                 | ({31'h0000_0000, tick_enable} << citc_pkg::CTRL_ENABLE_BIT);
  assign rd_calib = (32'h0000_0001 << citc_pkg::CALIB_NO_REFERENCE_FLAG_BIT)           // see (RL6)
                  | {8'h00, citc_pkg::TEN_MS_COUNT};                       // see (RL5)
  assign rd_stat  = ({31'h0000_0000, nmi_request} << citc_pkg::STAT_NMI_BIT)
                  | ({31'h0000_0000, count_flag} << citc_pkg::STAT_FLAG_BIT);

  assign next_rdata = hit_ctrl  ? rd_ctrl :
                      hit_load  ? {8'h00, tick_reload} :
                      hit_cur   ? {8'h00, tick_count} :
                      hit_calib ? rd_calib :
                      hit_prio  ? prio_word[prio_idx] :
                      hit_mux   ? {29'h0000_0000, pin_mux_sel} :
                      hit_stat  ? rd_stat : citc_pkg::WORD_ZERO;

  // captured in the setup cycle so the access phase sees a flop output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= citc_pkg::WORD_ZERO;
    else if (apb_setup & ~pwrite)
      prdata <= next_rdata;
  end

endmodule

//--- design/citc_pkg.sv
// shared constants, register map and bus carriers for the core configuration glue
package citc_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_TICK_CTRL  = 8'h00;
  localparam logic [7:0] OFF_TICK_LOAD  = 8'h04;
  localparam logic [7:0] OFF_TICK_CUR   = 8'h08;
  localparam logic [7:0] OFF_TICK_CALIB = 8'h0C;
  localparam logic [7:0] OFF_PRIO_BASE  = 8'h10;
  localparam logic [7:0] OFF_NMI_MUX    = 8'h20;
  localparam logic [7:0] OFF_STATUS     = 8'h24;
  localparam int         ADDR_W         = 8;

  // tick control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TICKINT_BIT = 1;
  localparam int CTRL_CLKSEL_BIT = 2;
  localparam int CTRL_FLAG_BIT   = 16;

  // tick counter width and calibration layout
  localparam int         TICK_W         = 24;
  localparam logic [23:0] TICK_ZERO     = 24'h00_0000;
  localparam logic [23:0] TICK_ONE      = 24'h00_0001;
  localparam logic [23:0] TEN_MS_COUNT  = 24'h00_0000;
  localparam int         CALIB_NO_REFERENCE_FLAG_BIT = 31;
  localparam int         CALIB_SKEW_BIT  = 30;

  // priority layout: 16 levels, 4-bit fields in the upper nibble of each byte
  localparam int PRIO_BITS    = 4;
  localparam int PRIO_REGS    = 4;
  localparam int PRIO_SOURCES = 16;
  localparam int PRIO_LSB     = 4;
  localparam logic [31:0] PRIO_MASK = 32'hF0F0_F0F0;

  // nmi pin multiplexer
  localparam int         MUX_W        = 3;
  localparam logic [2:0] MUX_NMI_FUNC = 3'h7;
  localparam logic [2:0] MUX_RESET    = 3'h0;
  localparam int         STAT_NMI_BIT = 0;
  localparam int         STAT_FLAG_BIT = 1;

  // common reset values
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // one request on a crossbar master port
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } citc_req_t;

  // owner of the transfer on the merged code port
  typedef enum logic {
    CITC_OWN_FETCH,
    CITC_OWN_DATA
  } citc_owner_t;

endpackage

//--- design/citc_nmi_gate.sv
// non-maskable request derivation from the external pin and its mux setting
`timescale 1ns/1ps
module citc_nmi_gate
(
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // pin and multiplexer setting
  input  wire logic                      nmi_pin_n,
  input  wire logic [citc_pkg::MUX_W-1:0] pin_mux_sel,
  // request to the vectored irq controller
  output logic                           nmi_request
);

  // pin counts only when the mux routes it to the nmi function
  wire mux_is_nmi;
  wire next_request;

  assign mux_is_nmi   = (pin_mux_sel == citc_pkg::MUX_NMI_FUNC); // see (RL9)
  assign next_request = mux_is_nmi & ~nmi_pin_n;                 // see (RL8) see (RL10)

  // registered so the controller sees a clean level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_request <= 1'b0;
    else
      nmi_request <= next_request;
  end

endmodule

//--- tb/citc_props.sv
// concurrent checks on the ports of the core configuration glue
`timescale 1ns/1ps
module citc_props
(
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb slave side
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  // code and system ports
  input wire logic                data_code_bus_valid,
  input wire logic                data_code_bus_ready,
  input wire citc_pkg::citc_req_t data_code_bus_req,
  input wire logic                fetch_valid,
  input wire citc_pkg::citc_req_t fetch_req,
  input wire logic                fetch_ready,
  input wire logic                code_valid,
  input wire citc_pkg::citc_req_t code_req,
  input wire logic                code_ready,
  input wire logic                sys_in_valid,
  input wire logic                sys_in_ready,
  input wire citc_pkg::citc_req_t sys_in_req,
  input wire logic                sys_valid,
  input wire citc_pkg::citc_req_t sys_req,
  input wire logic                sys_ready,
  // nmi and priorities
  input wire logic                nmi_pin_n,
  input wire logic                nmi_request,
  input wire logic [63:0]         irq_priority
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase decodes
  wire        acc     = psel && penable;
  wire        rd_acc  = acc && !pwrite;
  wire        in_prio = paddr >= 32'h0000_0010 && paddr <= 32'h0000_001C;
  wire        wr_prio = acc && pwrite && in_prio;
  wire [1:0]  widx    = paddr[3:2];
  wire [15:0] nib     = {pwdata[31:28], pwdata[23:20], pwdata[15:12], pwdata[7:4]};
  // shadow of the pin mux: the gate is internal, so it is rebuilt from apb writes
  logic [2:0] mux_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mux_q <= 3'h0;
    else if (acc && pwrite && paddr == 32'h0000_0020)
      mux_q <= pwdata[2:0];
  AST_NMI_FOLLOW: assert property (mux_q == 3'h7 && !nmi_pin_n |=> nmi_request)
    else $error("nmi request missing");
  AST_NMI_IDLE: assert property (nmi_pin_n || mux_q != 3'h7 |=> !nmi_request)
    else $error("nmi request without low pin and nmi mux");
  AST_CALIB: assert property (rd_acc && paddr == 32'h0000_000C |-> prdata == 32'h8000_0000)
    else $error("calibration word wrong");
  AST_CLKSEL: assert property (rd_acc && paddr == 32'h0000_0000 |-> prdata[2])
    else $error("tick clock select reads zero");
  AST_PRIO_LOW: assert property (rd_acc && in_prio |-> (prdata & 32'h0F0F_0F0F) == 32'h0000_0000)
    else $error("priority low nibble not zero");
  AST_PRIO_MAP: assert property (wr_prio |=> irq_priority[{$past(widx), 4'h0} +: 16] == $past(nib))
    else $error("priority outputs do not follow write");
  AST_CODE_ONE: assert property (data_code_bus_valid && data_code_bus_ready |=> code_valid && code_req == $past(data_code_bus_req))
    else $error("data code request not placed on the code port");
  AST_FETCH_ISSUE: assert property (fetch_valid && fetch_ready |=> code_valid && code_req == $past(fetch_req))
    else $error("fetch request not placed on the code port");
  AST_CODE_HOLD: assert property (code_valid && !code_ready |=> code_valid && $stable(code_req))
    else $error("code request dropped or changed");
  AST_SYS_HOLD: assert property (sys_valid && !sys_ready |=> sys_valid && $stable(sys_req))
    else $error("system request dropped or changed");
  AST_SYS_ISSUE: assert property (sys_in_valid && sys_in_ready |=> sys_valid && sys_req == $past(sys_in_req))
    else $error("system request not forwarded");
  // main scenarios reached
  cover property (nmi_request);
  cover property (code_valid && !code_ready);
  cover property (sys_valid && sys_ready);
endmodule

bind citc_core_config citc_props u_props (.*);

//--- tb/citc_xbar_model.sv
// crossbar stand-in answering the code and system master ports
`timescale 1ns/1ps
module citc_xbar_model
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // stall control from the bench
  input  wire logic                slow,
  // code port
  input  wire logic                code_valid,
  input  wire citc_pkg::citc_req_t code_req,
  output logic                     code_ready,
  output logic                     code_rvalid,
  output logic [31:0]              code_rdata,
  // system port
  input  wire logic                sys_valid,
  output logic                     sys_ready
);
  logic [7:0]  lfsr;      // stall pattern
  logic [1:0]  pend;      // read answer delay line
  logic [31:0] pend_addr; // address of the read in flight
  // random stalls when slow; data line toggles off-answer so stale data never passes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lfsr <= 8'h5b;
      pend <= 2'b00;
      {code_ready, sys_ready, code_rvalid, pend_addr, code_rdata} <= '0;
    end
    else
    begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      code_ready <= !slow || lfsr[0];
      sys_ready <= !slow || lfsr[1];
      pend <= {pend[0], code_valid && code_ready && !code_req.write};
      if (code_valid && code_ready)
        pend_addr <= code_req.addr;
      code_rvalid <= pend[1];
      code_rdata <= pend[1] ? pend_addr ^ 32'h5A5A_0000 : ~code_rdata;
    end
endmodule

//--- tb/test_core_interrupt_tick_config.sv
// self-checking bench for the core configuration glue
`timescale 1ns/1ps
module test_core_interrupt_tick_config;
  // stimulus
  logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                fetch_valid = 1'b0, data_code_bus_valid = 1'b0, sys_in_valid = 1'b0;
  logic                nmi_pin_n = 1'b1, slow = 1'b0;
  logic [31:0]         paddr = '0, pwdata = '0, seed = 32'hb757;
  citc_pkg::citc_req_t fetch_req = '0, data_code_bus_req = '0, sys_in_req = '0;
  // observed
  logic                pready, pslverr, fetch_ready, fetch_rvalid, data_code_bus_ready, data_code_bus_rvalid, er;
  logic                code_valid, code_ready, code_rvalid, sys_in_ready, sys_valid, sys_ready;
  logic                nmi_request, tick_event;
  logic [31:0]         prdata, fetch_rdata, data_code_bus_rdata, code_rdata, rd;
  citc_pkg::citc_req_t code_req, sys_req;
  logic [63:0]         irq_priority;
  // bookkeeping and behavioural model
  int                  fail_count = 0, total_checks = 0, cycles = 0, n;
  logic [31:0]         prio_q[4];
  logic [31:0]         exp_q[$];

  citc_core_config dut (.*);
  citc_xbar_model u_xbar (.*);

  always #2 pclk = ~pclk;
  // a hang counts as a mismatch
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // one read on a code source, answer compared with the model queue
  task code_rd(input logic fetch, input logic [31:0] a);
    @(posedge pclk);
    exp_q.push_back(a ^ 32'h5A5A_0000);
    if (fetch)
      {fetch_valid, fetch_req} <= {1'b1, a, 1'b0, 32'h0};
    else
      {data_code_bus_valid, data_code_bus_req} <= {1'b1, a, 1'b0, 32'h0};
    do @(posedge pclk); while ((fetch ? fetch_ready : data_code_bus_ready) !== 1'b1);
    {fetch_valid, data_code_bus_valid} <= 2'b00;
    do @(posedge pclk); while ((fetch ? fetch_rvalid : data_code_bus_rvalid) !== 1'b1);
    chk(fetch ? fetch_rdata : data_code_bus_rdata, exp_q.pop_front());
  endtask

  // one write on the system bus, seen on its own port
  task sys_wr(input logic [31:0] a);
    @(posedge pclk);
    {sys_in_valid, sys_in_req} <= {1'b1, a, 1'b1, ~a};
    do @(posedge pclk); while (sys_in_ready !== 1'b1);
    sys_in_valid <= 1'b0;
    do @(posedge pclk); while ((sys_valid && sys_ready) !== 1'b1);
    chk(sys_req.addr, a);
    chk(sys_req.wdata, ~a);
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // calibration is read only and fixed
    apb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h8000_0000);
    // tick on core clock: reload 5 gives a period of 6 cycles
    apb(1'b1, 32'h0000_0004, 32'h0000_0005);
    apb(1'b1, 32'h0000_0008, 32'h0);
    apb(1'b1, 32'h0000_0000, 32'h0000_0003);
    apb(1'b0, 32'h0000_0000, 32'h0);
    chk(32'(rd[2]), 32'h1);
    do @(posedge pclk); while (tick_event !== 1'b1);
    n = 0;
    do begin @(posedge pclk); n++; end while (tick_event !== 1'b1);
    chk(32'(n), 32'h6);
    apb(1'b1, 32'h0000_0000, 32'h0);
    // wraps left the count flag set; a control read clears it
    apb(1'b0, 32'h0000_0024, 32'h0);
    chk(32'(rd[1]), 32'h1);
    apb(1'b0, 32'h0000_0000, 32'h0);
    chk(32'(rd[16]), 32'h1);
    apb(1'b0, 32'h0000_0024, 32'h0);
    chk(32'(rd[1]), 32'h0);
    // priorities: random words, only upper nibbles kept
    for (int w = 0; w < 4; w++)
    begin
      seed = xs(seed);
      prio_q[w] = seed & 32'hF0F0_F0F0;
      apb(1'b1, 32'h10 + 4 * w, seed);
      apb(1'b0, 32'h10 + 4 * w, 32'h0);
      chk(rd, prio_q[w]);
      for (int b = 0; b < 4; b++)
        chk(32'(irq_priority[16 * w + 4 * b +: 4]), 32'(prio_q[w][8 * b + 4 +: 4]));
    end
    // nmi over every mux code and both pin levels
    for (int m = 0; m < 16; m++)
    begin
      apb(1'b1, 32'h0000_0020, 32'(m >> 1));
      nmi_pin_n <= m[0];
      repeat (2) @(posedge pclk);
      chk(32'(nmi_request), 32'(m >> 1 == 7 && !m[0]));
      apb(1'b0, 32'h0000_0024, 32'h0);
      chk(32'(rd[0]), 32'(m >> 1 == 7 && !m[0]));
    end
    // unmapped offset is refused
    apb(1'b0, 32'h0000_0030, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // code and system ports, prompt then stalling far side
    for (int i = 0; i < 8; i++)
    begin
      slow <= (i > 3);
      seed = xs(seed);
      code_rd(seed[0], {seed[31:2], 2'b00});
      sys_wr({seed[30:1], 2'b00});
    end
    stop_test();
  end
endmodule
